// ### shared/mod_fx_pkg.sv
// Package: constants and types for the modulation effect control block
package mod_fx_pkg;

  // Effect function selector
  typedef enum logic [2:0] {
    FN_LFO_DELAY   = 3'h0,
    FN_ROTARY      = 3'h1,
    FN_AUTOPAN_FM  = 3'h2,
    FN_PITCH       = 3'h3,
    FN_PITCH_FBK   = 3'h4
  } fx_function_t;

  // Sub-mode of the lfo delay function
  typedef enum logic [1:0] {
    SUB_PHASING  = 2'h0,
    SUB_FLANGING = 2'h1,
    SUB_CHORUS   = 2'h2
  } lfo_sub_t;

  // Register offsets
  localparam logic [3:0] OFS_FUNCTION   = 4'h0;
  localparam logic [3:0] OFS_SUBMODE    = 4'h1;
  localparam logic [3:0] OFS_SPEED      = 4'h2;
  localparam logic [3:0] OFS_DEPTH      = 4'h3;
  localparam logic [3:0] OFS_FEEDBACK   = 4'h4;
  localparam logic [3:0] OFS_RATE1      = 4'h5;
  localparam logic [3:0] OFS_RATE2      = 4'h6;
  localparam logic [3:0] OFS_ACCEL      = 4'h7;
  localparam logic [3:0] OFS_ROT_DEPTH  = 4'h8;
  localparam logic [3:0] OFS_MIDI_CFG   = 4'h9;
  localparam logic [3:0] OFS_ECHO_MONO  = 4'ha;
  localparam logic [3:0] OFS_STATUS     = 4'hb;

  // Midi config fields: [6:0] controller, [10:7] channel, [11] toggle
  localparam int MIDI_CC_LSB   = 0;
  localparam int MIDI_CH_LSB   = 7;
  localparam int MIDI_TOG_BIT  = 11;
  // Function reg: bit 3 = initial rate selects second
  localparam int INIT_SEL_BIT  = 3;

  // Reset values
  localparam logic [6:0]  RST_CONTROLLER = 7'h01;
  localparam logic [3:0]  RST_CHANNEL    = 4'h0;
  localparam logic [15:0] RST_RATE1      = 16'h0010;
  localparam logic [15:0] RST_RATE2      = 16'h0080;
  localparam logic [7:0]  RST_ACCEL      = 8'h14;
  localparam logic [7:0]  RST_DEPTH      = 8'h32;

  localparam logic [6:0]  CC_THRESHOLD   = 7'h40;

  // Base delays in samples
  localparam logic [15:0] BASE_PHASING   = 16'h0010;
  localparam logic [15:0] BASE_FLANGING  = 16'h0040;
  localparam logic [15:0] BASE_CHORUS    = 16'h0200;

  // Control tick: 1 ms; acceleration in tenths of a second
  localparam int CLOCK_HZ        = 20_000_000;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYCLES     = CLOCK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_TENTH = 100;

  // Midi controller message after parsing
  typedef struct packed {
    logic [3:0] channel;
    logic [6:0] number;
    logic [6:0] value;
  } cc_msg_t;

  // Stereo sample pair
  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } stereo_t;

endpackage : mod_fx_pkg

// ### rtl/lfo_phase_gen.sv
// Module: phase accumulator lfo with triangle output
`timescale 1ns/1ps
module lfo_phase_gen #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  // Control
  input  wire logic             i_tick,
  input  wire logic [WIDTH-1:0] i_increment,
  // Output
  output logic      [WIDTH-1:0] o_phase,
  output logic      [WIDTH-1:0] o_triangle
);
  initial begin
    if (WIDTH < 4) $error("lfo width too small");
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) o_phase <= '0;
    else if (i_tick) o_phase <= o_phase + i_increment;
  end

  // Fold top half down to give a triangle
  always_comb begin
    if (o_phase[WIDTH-1]) o_triangle = ~{o_phase[WIDTH-2:0], 1'b0};
    else o_triangle = {o_phase[WIDTH-2:0], 1'b0};
  end
endmodule : lfo_phase_gen

// ### rtl/modulation_effect_control.sv
// Module: control for the stereo modulation effect stage
`timescale 1ns/1ps
module modulation_effect_control
  import mod_fx_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_srst,
  // Register port
  input  wire logic [3:0]              i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [15:0]             o_rdata,
  // Midi controller messages
  input  wire mod_fx_pkg::cc_msg_t     i_cc,
  input  wire logic                    i_cc_valid,
  // Audio stream from eq, towards echo
  input  wire mod_fx_pkg::stereo_t     i_sample,
  input  wire logic                    i_sample_valid,
  output mod_fx_pkg::stereo_t          o_effect_in,
  output logic                         o_sample_valid,
  // Delay line control
  output logic      [15:0]             o_tap_len [4],
  output logic      [15:0]             o_rotor_rate,
  output logic      [7:0]              o_rotor_width
);
  import mod_fx_pkg::*;

  initial begin
    if (TICK_COUNT < 1) $error("tick count must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  fx_function_t     fx_function;
  logic             init_second;
  lfo_sub_t         sub_mode;
  logic [15:0]      speed;
  logic [7:0]       depth;
  logic signed [7:0] feedback;
  logic [15:0]      first_rotation_rate;
  logic [15:0]      second_rotation_rate;
  logic [7:0]       accel;
  logic [7:0]       rot_depth;
  logic [6:0]       trig_controller;
  logic [3:0]       trig_channel;
  logic             toggle_mode;
  logic             echo_mono;
  logic             use_second;
  logic             gliding;
  logic [15:0]      rate;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      fx_function          <= FN_LFO_DELAY;
      init_second          <= 1'b0;
      sub_mode             <= SUB_CHORUS;
      speed                <= RST_RATE1;
      depth                <= RST_DEPTH;
      feedback             <= '0;
      first_rotation_rate  <= RST_RATE1;
      second_rotation_rate <= RST_RATE2;
      accel                <= RST_ACCEL;
      rot_depth            <= RST_DEPTH;
      trig_controller      <= RST_CONTROLLER;
      trig_channel         <= RST_CHANNEL;
      toggle_mode          <= 1'b0;
      echo_mono            <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        OFS_FUNCTION: begin
          // Values past the fifth function are kept off the selector
          if (i_wdata[2:0] <= 3'h4) begin
            fx_function <= fx_function_t'(i_wdata[2:0]);
          end
          init_second <= i_wdata[INIT_SEL_BIT];
        end
        OFS_SUBMODE: begin
          if (i_wdata[1:0] != 2'h3) sub_mode <= lfo_sub_t'(i_wdata[1:0]);
        end
        OFS_SPEED:     speed <= i_wdata;
        OFS_DEPTH:     depth <= i_wdata[7:0];
        OFS_FEEDBACK:  feedback <= i_wdata[7:0];
        OFS_RATE1:     first_rotation_rate <= i_wdata;
        OFS_RATE2:     second_rotation_rate <= i_wdata;
        OFS_ACCEL:     accel <= i_wdata[7:0];
        OFS_ROT_DEPTH: rot_depth <= i_wdata[7:0];
        OFS_MIDI_CFG: begin
          trig_controller <= i_wdata[MIDI_CC_LSB +: 7];
          trig_channel    <= i_wdata[MIDI_CH_LSB +: 4];
          toggle_mode     <= i_wdata[MIDI_TOG_BIT];
        end
        OFS_ECHO_MONO: echo_mono <= i_wdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) o_rdata <= '0;
    else if (i_rd) begin
      case (i_addr)
        OFS_FUNCTION:  o_rdata <= {12'h000, init_second, fx_function};
        OFS_SUBMODE:   o_rdata <= {14'h0000, sub_mode};
        OFS_SPEED:     o_rdata <= speed;
        OFS_DEPTH:     o_rdata <= {8'h00, depth};
        OFS_FEEDBACK:  o_rdata <= {8'h00, feedback};
        OFS_RATE1:     o_rdata <= first_rotation_rate;
        OFS_RATE2:     o_rdata <= second_rotation_rate;
        OFS_ACCEL:     o_rdata <= {8'h00, accel};
        OFS_ROT_DEPTH: o_rdata <= {8'h00, rot_depth};
        OFS_MIDI_CFG:
          o_rdata <= {4'h0, toggle_mode, trig_channel, trig_controller};
        OFS_ECHO_MONO: o_rdata <= {15'h0000, echo_mono};
        OFS_STATUS:    o_rdata <= {14'h0000, gliding, use_second};
        default:       o_rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control tick
  logic [31:0] tick_cnt;
  logic        tick;

  always_ff @(posedge i_clock) begin
    if (i_srst) tick_cnt <= '0;
    else if (tick_cnt == 32'(TICK_COUNT - 1)) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 32'h1;
  end
  assign tick = (tick_cnt == 32'(TICK_COUNT - 1));

  ////////////////////////////////////////////////////////////////////////
  // LFO and delay taps
  logic [15:0] lfo_phase;
  logic [15:0] tri_wave;

  lfo_phase_gen #(
    .WIDTH (16)
  ) u_lfo (
    .i_clock     (i_clock),
    .i_srst      (i_srst),
    .i_tick      (tick),
    .i_increment (speed),
    .o_phase     (lfo_phase),
    .o_triangle  (tri_wave)
  );

  logic [15:0] base_len;
  always_comb begin
    case (sub_mode)
      SUB_PHASING:  base_len = BASE_PHASING;
      SUB_FLANGING: base_len = BASE_FLANGING;
      default:      base_len = BASE_CHORUS;
    endcase
  end

  // In chorus each tap reads the triangle at its own quarter-cycle offset; otherwise taps 0 and 1 take it straight and inverted
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tap
      logic [15:0] ph;
      logic [15:0] tw;
      logic [23:0] prod;
      assign ph = lfo_phase + 16'(g * 16'h4000);
      always_comb begin
        if (sub_mode != SUB_CHORUS && g == 1) tw = ~tri_wave;
        else if (sub_mode != SUB_CHORUS) tw = tri_wave;
        else if (ph[15]) tw = ~{ph[14:0], 1'b0};
        else tw = {ph[14:0], 1'b0};
      end
      assign prod = tw * depth;
      always_ff @(posedge i_clock) begin
        if (i_srst) o_tap_len[g] <= '0;
        else if (fx_function != FN_LFO_DELAY) o_tap_len[g] <= '0;
        else if (sub_mode != SUB_CHORUS && g > 1) o_tap_len[g] <= '0;
        else o_tap_len[g] <= base_len + {8'h00, prod[23:16]};
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Audio path: feedback and mono sum
  stereo_t            fb_sum;
  logic signed [23:0] fb_l;
  logic signed [23:0] fb_r;
  logic signed [16:0] mono;

  // Sign of feedback carries the inversion
  assign fb_l = o_effect_in.left * feedback;
  assign fb_r = o_effect_in.right * feedback;
  always_comb begin
    fb_sum.left  = i_sample.left + fb_l[22:7];
    fb_sum.right = i_sample.right + fb_r[22:7];
  end
  assign mono = 17'(fb_sum.left) + 17'(fb_sum.right);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_effect_in    <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= i_sample_valid;
      if (i_sample_valid) begin
        if (echo_mono) begin
          o_effect_in.left  <= mono[16:1];
          o_effect_in.right <= mono[16:1];
        end else o_effect_in <= fb_sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rotary rate trigger
  logic       cc_hit;
  logic       cc_high;
  logic       prev_high;
  logic       entered;
  logic       prev_rotary;

  assign cc_hit  = i_cc_valid && i_cc.channel == trig_channel
                   && i_cc.number == trig_controller;
  assign cc_high = (i_cc.value >= CC_THRESHOLD);
  assign entered = (fx_function == FN_ROTARY) && !prev_rotary;

  always_ff @(posedge i_clock) begin
    if (i_srst) prev_rotary <= 1'b0;
    else prev_rotary <= (fx_function == FN_ROTARY);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      use_second <= 1'b0;
      prev_high  <= 1'b0;
    end else if (entered) begin
      use_second <= init_second;
      prev_high  <= 1'b0;
    end else if (cc_hit) begin
      prev_high <= cc_high;
      if (!toggle_mode) use_second <= cc_high;
      else if (cc_high && !prev_high) use_second <= !use_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate glide
  logic [15:0] target;
  logic [15:0] glide_from;
  logic [15:0] ticks_total;
  logic [15:0] ticks_done;
  logic        prev_second;
  logic [31:0] span;
  logic [15:0] span_mag;
  logic [31:0] progress;

  assign target      = use_second ? second_rotation_rate : first_rotation_rate;
  assign ticks_total = 16'(accel * TICKS_PER_TENTH);
  assign span_mag    = (target >= glide_from) ? target - glide_from
                                              : glide_from - target;
  assign span        = span_mag * ticks_done;
  assign progress    = span / {16'h0000, ticks_total};

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rate        <= RST_RATE1;
      glide_from  <= RST_RATE1;
      ticks_done  <= '0;
      gliding     <= 1'b0;
      prev_second <= 1'b0;
    end else if (entered) begin
      // Audition: named rate at once, never a glide from the old one
      rate        <= init_second ? second_rotation_rate
                                 : first_rotation_rate;
      prev_second <= init_second;
      gliding     <= 1'b0;
    end else begin
      prev_second <= use_second;
      if (ticks_total == 16'h0000) begin
        rate    <= target;
        gliding <= 1'b0;
      end else if (use_second != prev_second) begin
        glide_from <= rate;
        ticks_done <= '0;
        gliding    <= 1'b1;
      end else if (!gliding) rate <= target;
      else if (tick) begin
        if (ticks_done + 16'h1 >= ticks_total) begin
          rate    <= target;
          gliding <= 1'b0;
        end else begin
          ticks_done <= ticks_done + 16'h1;
          // Linear from start: no accumulated rounding drift
          if (target >= glide_from) rate <= glide_from + progress[15:0];
          else rate <= glide_from - progress[15:0];
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_rotor_rate  <= '0;
      o_rotor_width <= '0;
    end else if (fx_function == FN_ROTARY) begin
      o_rotor_rate  <= rate;
      o_rotor_width <= rot_depth;
    end else begin
      o_rotor_rate  <= '0;
      o_rotor_width <= '0;
    end
  end
endmodule : modulation_effect_control

// ### tb/midi_cc_source.sv
// Partner model: controller that sends parsed midi controller messages
`timescale 1ns/1ps
module midi_cc_source (
  // Clock
  input  wire logic          i_clock,
  // Messages towards the block
  output mod_fx_pkg::cc_msg_t o_cc,
  output logic               o_cc_valid
);
  import mod_fx_pkg::*;

  initial begin
    o_cc = '1;
    o_cc_valid = 1'b0;
  end

  // Caller picks level for sweeps, toggle for pushes
  task automatic send(input logic [3:0] ch, input logic [6:0] num,
                      input logic [6:0] val);
    o_cc <= '{channel: ch, number: num, value: val};
    o_cc_valid <= 1'b1;
    @(posedge i_clock);
    o_cc_valid <= 1'b0;
    // Idle bus shows the inverse so a stale message never looks valid
    o_cc <= ~o_cc;
    @(posedge i_clock);
  endtask : send

endmodule : midi_cc_source

// ### tb/modulation_effect_control_monitor.sv
// Checker: port assertions for the modulation effect control
`timescale 1ns/1ps
module modulation_effect_control_monitor
  import mod_fx_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input wire logic                i_clock,
  input wire logic                i_srst,
  input wire logic [3:0]          i_addr,
  input wire logic [15:0]         i_wdata,
  input wire logic                i_wr,
  input wire logic                i_rd,
  input wire logic [15:0]         o_rdata,
  input wire mod_fx_pkg::cc_msg_t i_cc,
  input wire logic                i_cc_valid,
  input wire mod_fx_pkg::stereo_t i_sample,
  input wire logic                i_sample_valid,
  input wire mod_fx_pkg::stereo_t o_effect_in,
  input wire logic                o_sample_valid,
  input wire logic [15:0]         o_tap_len [4],
  input wire logic [15:0]         o_rotor_rate,
  input wire logic [7:0]          o_rotor_width
);
  // Shadow copies; seen gates each until software has written it
  logic [2:0] fn;
  logic [1:0] sub;
  logic [7:0] fb;
  logic       mono;
  logic [7:0] rdep;
  logic [4:0] seen;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      seen <= 5'h0;
      mono <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == OFS_FUNCTION && i_wdata[2:0] <= 3'h4) begin
        fn <= i_wdata[2:0];
        seen[0] <= 1'b1;
      end
      if (i_addr == OFS_SUBMODE && i_wdata[1:0] != 2'h3) begin
        sub <= i_wdata[1:0];
        seen[1] <= 1'b1;
      end
      if (i_addr == OFS_ROT_DEPTH) begin
        rdep <= i_wdata[7:0];
        seen[2] <= 1'b1;
      end
      if (i_addr == OFS_FEEDBACK) begin
        fb <= i_wdata[7:0];
        seen[3] <= 1'b1;
      end
      if (i_addr == OFS_ECHO_MONO) begin
        mono <= i_wdata[0];
        seen[4] <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  sequence s_no_lfo;
    (seen[0] && fn != FN_LFO_DELAY) [*3];
  endsequence
  sequence s_no_rot;
    (seen[0] && fn != FN_ROTARY) [*3];
  endsequence
  sequence s_narrow;
    (&seen[1:0] && fn == FN_LFO_DELAY && sub != SUB_CHORUS) [*3];
  endsequence
  sequence s_flange;
    (&seen[1:0] && fn == FN_LFO_DELAY && sub == SUB_FLANGING) [*3];
  endsequence
  sequence s_plain;
    (&seen[4:3] && fb == 8'h0 && !mono) [*2];
  endsequence

  chk_valid_follow: assert property (
    i_sample_valid |=> o_sample_valid) else $error("valid lost");
  chk_taps_idle: assert property (
    s_no_lfo |-> (o_tap_len[0] | o_tap_len[1]) == 16'h0)
    else $error("taps not idle");
  chk_rotor_idle: assert property (
    s_no_rot |-> o_rotor_rate == 16'h0) else $error("rotor not idle");
  chk_upper_taps: assert property (
    s_narrow |-> (o_tap_len[2] | o_tap_len[3]) == 16'h0)
    else $error("upper taps in use");
  chk_flange_base: assert property (
    s_flange |-> o_tap_len[0] >= BASE_FLANGING
    && o_tap_len[1] >= BASE_FLANGING) else $error("flange too short");
  chk_width_depth: assert property (
    (&seen[2:0] && fn == FN_ROTARY && $stable(rdep)) [*3]
    |-> o_rotor_width == rdep)
    else $error("width off");
  chk_effect_pass: assert property (
    s_plain ##0 i_sample_valid |=> o_effect_in == $past(i_sample))
    else $error("effect input off");
  chk_mono_sum: assert property (
    seen[4] && mono && $past(mono) && i_sample_valid
    |=> o_effect_in.left == o_effect_in.right) else $error("not mono");
  chk_read_unmapped: assert property (
    i_rd && i_addr > OFS_STATUS |=> o_rdata == 16'h0)
    else $error("unmapped read");
  chk_rdata_hold: assert property (
    !i_rd |=> $stable(o_rdata)) else $error("read data moved");

endmodule : modulation_effect_control_monitor

bind modulation_effect_control modulation_effect_control_monitor #(
  .TICK_COUNT(TICK_COUNT)
) u_monitor (
  .i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_cc(i_cc), .i_cc_valid(i_cc_valid), .i_sample(i_sample),
  .i_sample_valid(i_sample_valid), .o_effect_in(o_effect_in),
  .o_sample_valid(o_sample_valid), .o_tap_len(o_tap_len),
  .o_rotor_rate(o_rotor_rate), .o_rotor_width(o_rotor_width)
);

// ### tb/modulation_effect_control_test.sv
// Testbench: scenarios for the modulation effect control
`timescale 1ns/1ps
module modulation_effect_control_test;
  import mod_fx_pkg::*;

  logic        i_clock = 1'b0;
  logic        i_srst = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [15:0] o_rdata;
  cc_msg_t     i_cc;
  logic        i_cc_valid;
  stereo_t     i_sample = '0;
  logic        i_sample_valid = 1'b0;
  stereo_t     o_effect_in;
  logic        o_sample_valid;
  logic [15:0] o_tap_len [4];
  logic [15:0] o_rotor_rate;
  logic [7:0]  o_rotor_width;
  logic [15:0] rv;
  int          mismatches = 0;
  int          n_tests = 0;

  localparam logic [15:0] BASES [3] = '{BASE_PHASING, BASE_FLANGING,
                                        BASE_CHORUS};
  // {channel, controller, value, expected rate}; level first, toggle at 4
  localparam logic [25:0] CC_TAB [9] = '{
    {4'h8, 7'h7f, 7'd100, 8'h20}, {4'h9, 7'h01, 7'd100, 8'h20},
    {4'h9, 7'h7f, 7'd64, 8'h84}, {4'h9, 7'h7f, 7'd63, 8'h20},
    {4'h9, 7'h7f, 7'd0, 8'h20}, {4'h9, 7'h7f, 7'd100, 8'h84},
    {4'h9, 7'h7f, 7'd127, 8'h84}, {4'h9, 7'h7f, 7'd63, 8'h84},
    {4'h9, 7'h7f, 7'd64, 8'h20}};

  always #25 i_clock = ~i_clock;

  modulation_effect_control #(.TICK_COUNT(4)) u_modulation_effect_control (
    .i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cc(i_cc), .i_cc_valid(i_cc_valid), .i_sample(i_sample),
    .i_sample_valid(i_sample_valid), .o_effect_in(o_effect_in),
    .o_sample_valid(o_sample_valid), .o_tap_len(o_tap_len),
    .o_rotor_rate(o_rotor_rate), .o_rotor_width(o_rotor_width));

  midi_cc_source u_midi_cc_source (
    .i_clock(i_clock), .o_cc(i_cc), .o_cc_valid(i_cc_valid));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
  endtask : settle

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
    d = o_rdata;
  endtask : rd

  task automatic push(input stereo_t s);
    i_sample <= s;
    i_sample_valid <= 1'b1;
    @(posedge i_clock);
    i_sample_valid <= 1'b0;
    @(posedge i_clock);
  endtask : push

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(OFS_MIDI_CFG, rv);
    check(rv, 16'h0001);
    rd(4'hd, rv);
    for (int f = 0; f < 6; f++) begin
      wr(OFS_FUNCTION, 16'(f));
      rd(OFS_FUNCTION, rv);
      check(rv & 16'h7, f < 5 ? 16'(f) : 16'h4);
    end
  endtask : t_regs

  task automatic t_lfo;
    logic [15:0] s1;
    wr(OFS_FUNCTION, 16'h0);
    wr(OFS_SPEED, 16'h0);
    wr(OFS_DEPTH, 16'h0);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_SUBMODE, 16'(s));
      settle(4);
      check(o_tap_len[1], BASES[s]);
      check(o_tap_len[3], s == 2 ? BASE_CHORUS : 16'h0);
    end
    // Refused sub-mode must leave chorus running
    wr(OFS_SUBMODE, 16'h3);
    rd(OFS_SUBMODE, rv);
    check(rv, 16'h0002);
    wr(OFS_SPEED, 16'h0100);
    wr(OFS_DEPTH, 16'h00ff);
    settle(200);
    check(16'(o_tap_len[0] != o_tap_len[1] || o_tap_len[0] != o_tap_len[2]
              || o_tap_len[0] != o_tap_len[3]), 16'h1);
    wr(OFS_SUBMODE, 16'h0);
    settle(4);
    s1 = o_tap_len[0] + o_tap_len[1];
    rv = o_tap_len[0];
    settle(100);
    check(16'(o_tap_len[0] != rv), 16'h1);
    check(16'(16'(o_tap_len[0] + o_tap_len[1] - s1 + 16'h2) <= 16'h4),
          16'h1);
    wr(OFS_SPEED, 16'h0);
    settle(4);
    rv = o_tap_len[0];
    settle(50);
    check(o_tap_len[0], rv);
  endtask : t_lfo

  task automatic t_audio;
    stereo_t s;
    s = '{left: 16'sh1234, right: -16'sh0005};
    wr(OFS_FEEDBACK, 16'h0);
    wr(OFS_ECHO_MONO, 16'h0);
    push(s);
    check(o_effect_in.left, s.left);
    check(o_effect_in.right, s.right);
    // Minus one half of the last output: 0x1234 -> 0x091a, -5 -> -3
    wr(OFS_FEEDBACK, 16'h00c0);
    push(s);
    check(o_effect_in.left, 16'h091a);
    check(o_effect_in.right, 16'hfffd);
    wr(OFS_FEEDBACK, 16'h0);
    wr(OFS_ECHO_MONO, 16'h1);
    push(s);
    check(o_effect_in.left, o_effect_in.right);
    check(o_effect_in.left, 16'h0917);
    wr(OFS_ECHO_MONO, 16'h0);
  endtask : t_audio

  task automatic t_rotary;
    wr(OFS_RATE1, 16'h0020);
    wr(OFS_RATE2, 16'h0084);
    // Non-zero glide time: entering must still jump to the named rate
    wr(OFS_ACCEL, 16'h1);
    wr(OFS_ROT_DEPTH, 16'h005a);
    wr(OFS_FUNCTION, 16'h0009);
    settle(3);
    check(o_rotor_rate, 16'h0084);
    check(16'(o_rotor_width), 16'h005a);
    wr(OFS_FUNCTION, 16'h0);
    wr(OFS_FUNCTION, 16'h1);
    settle(3);
    check(o_rotor_rate, 16'h0020);
  endtask : t_rotary

  task automatic t_midi;
    wr(OFS_ACCEL, 16'h0);
    wr(OFS_MIDI_CFG, 16'h04ff);
    for (int i = 0; i < 9; i++) begin
      if (i == 4) wr(OFS_MIDI_CFG, 16'h0cff);
      u_midi_cc_source.send(CC_TAB[i][25:22], CC_TAB[i][21:15],
                            CC_TAB[i][14:8]);
      settle(4);
      check(o_rotor_rate, {8'h0, CC_TAB[i][7:0]});
    end
  endtask : t_midi

  task automatic t_glide;
    // One tenth of a second is 100 ticks of 4 cycles, one step per tick
    wr(OFS_ACCEL, 16'h1);
    u_midi_cc_source.send(4'h9, 7'h7f, 7'd0);
    u_midi_cc_source.send(4'h9, 7'h7f, 7'd100);
    settle(200);
    check(16'(o_rotor_rate > 16'h4d && o_rotor_rate < 16'h57), 16'h1);
    settle(230);
    check(o_rotor_rate, 16'h0084);
    u_midi_cc_source.send(4'h9, 7'h7f, 7'd0);
    u_midi_cc_source.send(4'h9, 7'h7f, 7'd100);
    settle(430);
    check(o_rotor_rate, 16'h0020);
  endtask : t_glide

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////
  initial begin
    settle(10);
    i_srst <= 1'b0;
    @(posedge i_clock);
    t_regs();
    t_lfo();
    t_audio();
    t_rotary();
    t_midi();
    t_glide();
    end_sim();
  end

  // Scenarios need about 1400 cycles
  initial begin
    settle(20000);
    mismatches++;
    end_sim();
  end

endmodule : modulation_effect_control_test
